/* src/decode_cfg.svh */
// Purpose: constants for the arithmetic/logic instruction decoder
// Assumes: included by bare name from the decoder files
// Notes: opcode fields, lengths, cycle counts, reset values
// Function
// - Instructions are 1, 2 or 3 bytes; length comes from the opcode.
// - Execution takes 2 to 8 cycles; multiply and divide take 8.
// - Add uses 28-2F register, 25 direct, 26-27 indirect, 24 immediate; 2 cycles.
// - Add-with-carry uses 38-3F, 35, 36-37, 34; 2 cycles each.
// - Subtract-with-borrow uses 98-9F, 95, 96-97, 94; 2 cycles each.
// - Increment uses 04 acc, 08-0F register, 05 direct, 06-07 indirect.
// - Decrement uses 14 acc, 18-1F register, 15 direct, 16-17 indirect.
// - Opcode A3 increments the data pointer; 1 byte, 4 cycles.
// - AND into acc uses 58-5F, 55, 56-57, 54; 2 cycles each.
// - AND into direct byte: 52 with acc 2 cycles, 53 immediate 4.
// - OR into acc uses 48-4F, 45, 46-47, 44; 2 cycles each.
// - XOR into acc uses 68-6F, 65, 66-67, 64; 2 cycles each.
// - XOR into direct byte: 62 with acc 2 cycles, 63 immediate 4.
// - Rotates 23 left, 33 left carry, 03 right, 13 right carry; 2 cycles.
// - Register forms pick the register from opcode bits 2:0.
`ifndef DECODE_CFG_SVH
`define DECODE_CFG_SVH

// ==========================================================
// Opcode high nibbles of the groups
`define HI_INC     4'h0
`define HI_DEC     4'h1
`define HI_ADD     4'h2
`define HI_ADD_WITH_CARRY    4'h3
`define HI_OR      4'h4
`define HI_AND     4'h5
`define HI_XOR     4'h6
`define HI_SUBTRACT_WITH_BORROW    4'h9

// ==========================================================
// Opcode low nibble forms
`define LO_DIRA    4'h2
`define LO_DIRI    4'h3
`define LO_IMM     4'h4
`define LO_DIR     4'h5
`define LO_IND     3'h3

// ==========================================================
// Whole opcodes
`define OPC_RR     8'h03
`define OPC_RRC    8'h13
`define OPC_RL     8'h23
`define OPC_RLC    8'h33
`define OPC_INCDP  8'ha3
`define OPC_MUL    8'ha4
`define OPC_DIV    8'h84

// ==========================================================
// Lengths and cycle counts
`define LEN_ONE    2'h1
`define LEN_TWO    2'h2
`define LEN_THREE  2'h3
`define CYC_SHORT  4'h2
`define CYC_LONG   4'h4
`define CYC_MULDIV 4'h8

// ==========================================================
// Reset values
`define PC_RST     16'h0000
`define ACC_RST    8'h00
`define B_RST      8'h00
`define DATA_POINTER_16_RST   16'h0000

`endif

/* src/decode_pkg.sv */
// Purpose: shared types of the instruction decoder
// Assumes: nothing beyond SystemVerilog
// Notes: constants live in decode_cfg.svh
package decode_pkg;

  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC,
    OP_AND, OP_OR, OP_XOR, OP_RL, OP_RLC, OP_RR, OP_RRC,
    OP_MUL, OP_DIV, OP_INCDP
  } op_t;

  // Operand source and result target
  typedef enum logic [2:0] {SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM} src_t;
  typedef enum logic [1:0] {DST_ACC, DST_OPND, DST_DATA_POINTER_16, DST_AB} dst_t;

  // One-hot sequencer states
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_BYTE2 = 4'b0010,
    ST_BYTE3 = 4'b0100,
    ST_EXEC  = 4'b1000
  } state_t;

  typedef struct packed {
    op_t        op;
    src_t       src;
    dst_t       dst;
    logic [1:0] len;
    logic [3:0] cyc;
  } dec_t;

endpackage

/* src/alu8.sv */
// Purpose: 8-bit arithmetic, logic, rotate, multiply and divide unit
// Assumes: purely combinational, flags come in from the caller
// Notes: divide by zero leaves A and B unchanged and sets overflow
`timescale 1ns/1ps
`include "decode_cfg.svh"
module alu8
  import decode_pkg::*;
(
  input  wire op_t        op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [7:0] bval,
  input  wire logic       cin,
  input  wire logic       vin,
  output logic      [7:0] res,
  output logic      [7:0] res_b,
  output logic            cout,
  output logic            ovf
);

  logic [8:0]  sum;
  logic [15:0] prod;
  logic        cy;

  // ==========================================================
  // Result and flags
  always_comb
  begin
    sum   = 9'h000;
    prod  = 16'h0000;
    cy    = 1'b0;
    res   = a;
    res_b = bval;
    cout  = cin;
    ovf   = vin;
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW:
      begin
        cy = (op == OP_ADD) ? 1'b0 : cin;
        if (op == OP_SUBTRACT_WITH_BORROW)
          sum = {1'b0, a} - {1'b0, b} - {8'h00, cy};
        else
          sum = {1'b0, a} + {1'b0, b} + {8'h00, cy};
        res  = sum[7:0];
        cout = sum[8];  // Borrow out on subtract
        if (op == OP_SUBTRACT_WITH_BORROW)
          ovf = (a[7] ^ b[7]) & (a[7] ^ sum[7]);
        else
          ovf = ~(a[7] ^ b[7]) & (a[7] ^ sum[7]);
      end
      OP_INC:  res = b + 8'h01;
      OP_DEC:  res = b - 8'h01;
      OP_AND:  res = a & b;
      OP_OR:   res = a | b;
      OP_XOR:  res = a ^ b;
      OP_RL:   res = {a[6:0], a[7]};
      OP_RLC:
      begin
        res  = {a[6:0], cin};
        cout = a[7];
      end
      OP_RR:   res = {a[0], a[7:1]};
      OP_RRC:
      begin
        res  = {cin, a[7:1]};
        cout = a[0];
      end
      OP_MUL:
      begin
        prod  = {8'h00, a} * {8'h00, bval};
        res   = prod[7:0];
        res_b = prod[15:8];
        cout  = 1'b0;
        ovf   = |prod[15:8];
      end
      OP_DIV:
      begin
        cout = 1'b0;
        ovf  = (bval == 8'h00);
        if (bval != 8'h00)
        begin
          res   = a / bval;
          res_b = a % bval;
        end
      end
      default: res = a;
    endcase
  end

endmodule

/* src/arith_logic_instr_decode.sv */
// Purpose: fetch, decode and execute arithmetic/logic/rotate opcodes
// Assumes: program and data memory answer in the same cycle
// Notes: writes to data memory are posted one cycle after completion
`timescale 1ns/1ps
`include "decode_cfg.svh"
module arith_logic_instr_decode
  import decode_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  bank_sel,
  input  wire logic        prog_ready,
  input  wire logic [7:0]  prog_data,
  output logic             prog_rd,
  output logic      [15:0] prog_addr,
  input  wire logic [7:0]  dmem_rdata,
  output logic             dmem_rd,
  output logic      [7:0]  dmem_raddr,
  output logic             dmem_wr,
  output logic      [7:0]  dmem_waddr,
  output logic      [7:0]  dmem_wdata,
  output logic      [7:0]  acc_out,
  output logic      [7:0]  b_out,
  output logic             carry_flag,
  output logic             ovf_flag,
  output logic      [15:0] data_pointer_16,
  output logic             instr_done,
  output logic             unsupported_op
);

  // ==========================================================
  // Decode table
  function automatic dec_t decode(input logic [7:0] opc);
    dec_t       d;
    logic [3:0] hi, lo;
    logic       ind, acc_form, dir_form, incdec;
    hi       = opc[7:4];
    lo       = opc[3:0];
    ind      = (lo[3:1] == `LO_IND);
    acc_form = opc[3] | ind | (lo == `LO_DIR) | (lo == `LO_IMM);
    dir_form = (lo == `LO_DIRA) | (lo == `LO_DIRI);
    incdec   = (hi == `HI_INC) | (hi == `HI_DEC);
    d        = '{op: OP_NONE, src: SRC_ACC, dst: DST_ACC,
                 len: `LEN_ONE, cyc: `CYC_SHORT};
    case (hi)
      `HI_ADD:  d.op = acc_form ? OP_ADD : OP_NONE;
      `HI_ADD_WITH_CARRY: d.op = acc_form ? OP_ADD_WITH_CARRY : OP_NONE;
      `HI_SUBTRACT_WITH_BORROW: d.op = acc_form ? OP_SUBTRACT_WITH_BORROW : OP_NONE;
      `HI_INC:  d.op = acc_form ? OP_INC : OP_NONE;
      `HI_DEC:  d.op = acc_form ? OP_DEC : OP_NONE;
      `HI_AND:  d.op = (acc_form | dir_form) ? OP_AND : OP_NONE;
      `HI_OR:   d.op = (acc_form | dir_form) ? OP_OR : OP_NONE;
      `HI_XOR:  d.op = (acc_form | dir_form) ? OP_XOR : OP_NONE;
      default:  d.op = OP_NONE;
    endcase
    if (d.op != OP_NONE)
    begin
      if (opc[3])
        d.src = SRC_REG;
      else if (ind)
        d.src = SRC_IND;
      else if (lo == `LO_DIR || dir_form)
        d.src = SRC_DIR;
      else
        d.src = incdec ? SRC_ACC : SRC_IMM;
      if (d.src == SRC_DIR || d.src == SRC_IMM)
        d.len = `LEN_TWO;
      if (dir_form || (incdec && d.src != SRC_ACC))
        d.dst = DST_OPND;
      if (lo == `LO_DIRI)
      begin
        d.len = `LEN_THREE;
        d.cyc = `CYC_LONG;
      end
    end
    // Single opcodes outside the grouped rows
    case (opc)
      `OPC_RL:    d.op = OP_RL;
      `OPC_RLC:   d.op = OP_RLC;
      `OPC_RR:    d.op = OP_RR;
      `OPC_RRC:   d.op = OP_RRC;
      `OPC_INCDP:
      begin
        d.op  = OP_INCDP;
        d.dst = DST_DATA_POINTER_16;
        d.cyc = `CYC_LONG;
      end
      `OPC_MUL, `OPC_DIV:
      begin
        d.op  = (opc == `OPC_MUL) ? OP_MUL : OP_DIV;
        d.dst = DST_AB;
        d.cyc = `CYC_MULDIV;
      end
      default: d.op = d.op;
    endcase
    return d;
  endfunction

  // ==========================================================
  // State
  state_t      state_ff, nxt_state;
  logic [15:0] pc_ff;
  logic [7:0]  opc_ff, byte2_ff, byte3_ff;
  logic [2:0]  step_ff;
  logic [7:0]  ptr_ff;
  logic [7:0]  acc_ff, b_ff;
  logic        cy_ff, ov_ff;
  logic [15:0] data_pointer_16_ff;
  logic        wr_ff;
  logic [7:0]  waddr_ff, wdata_ff;
  dec_t        dec_in, dec;
  logic        take, last;
  logic [7:0]  reg_addr, ind_addr, opnd_addr;
  logic [7:0]  opnd, alu_a, res, res_b;
  logic        cout, ovf;

  assign dec_in = decode(prog_data);
  assign dec    = decode(opc_ff);
  // Fetch handshake and completion strobe
  assign prog_rd        = (state_ff != ST_EXEC);
  assign take           = prog_rd & prog_ready;
  assign last           = (state_ff == ST_EXEC) && ({1'b0, step_ff} == dec.cyc - 4'h1);
  assign instr_done     = last;
  assign unsupported_op = last && (dec.op == OP_NONE);

  // ==========================================================
  // Sequencer: fetch as many bytes as the opcode asks for
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_FETCH: if (take) nxt_state = (dec_in.len == `LEN_ONE) ? ST_EXEC : ST_BYTE2;
      ST_BYTE2: if (take) nxt_state = (dec.len == `LEN_THREE) ? ST_BYTE3 : ST_EXEC;
      ST_BYTE3: if (take) nxt_state = ST_EXEC;
      ST_EXEC:  if (last) nxt_state = ST_FETCH;
      default:  nxt_state = ST_FETCH;
    endcase
  end

  // Program counter and instruction bytes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_FETCH;
      pc_ff    <= `PC_RST;
      opc_ff   <= 8'h00;
      byte2_ff <= 8'h00;
      byte3_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (take)
        pc_ff <= pc_ff + 16'h0001;
      if (take && state_ff == ST_FETCH)
        opc_ff <= prog_data;
      if (take && state_ff == ST_BYTE2)
        byte2_ff <= prog_data;
      if (take && state_ff == ST_BYTE3)
        byte3_ff <= prog_data;
    end
  end

  assign prog_addr = pc_ff;

  // Execute step count, runs up to the cycle budget of each opcode
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      step_ff <= 3'h0;
    else if (state_ff != ST_EXEC || last)
      step_ff <= 3'h0;
    else
      step_ff <= step_ff + 3'h1;
  end

  // ==========================================================
  // Operand addressing: step 0 reads register, direct or pointer
  always_comb
  begin
    reg_addr   = {3'b000, bank_sel, opc_ff[2:0]};
    ind_addr   = {3'b000, bank_sel, 2'b00, opc_ff[0]};
    opnd_addr  = (dec.src == SRC_REG) ? reg_addr : byte2_ff;
    dmem_rd    = 1'b0;
    dmem_raddr = 8'h00;
    if (state_ff == ST_EXEC && step_ff == 3'h0)
    begin
      dmem_rd    = (dec.src == SRC_REG) || (dec.src == SRC_DIR) || (dec.src == SRC_IND);
      dmem_raddr = (dec.src == SRC_IND) ? ind_addr : opnd_addr;
    end
    else if (state_ff == ST_EXEC && step_ff == 3'h1 && dec.src == SRC_IND)
    begin
      dmem_rd    = 1'b1;
      dmem_raddr = ptr_ff;
    end
  end

  // First read is held: operand value, or pointer for indirect forms
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      ptr_ff <= 8'h00;
    else if (dmem_rd && step_ff == 3'h0)
      ptr_ff <= dmem_rdata;
  end

  // Operand selection for the final step
  always_comb
  begin
    case (dec.src)
      SRC_IND:          opnd = dmem_rdata;
      SRC_REG, SRC_DIR: opnd = ptr_ff;
      SRC_IMM:          opnd = byte2_ff;
      default:          opnd = acc_ff;
    endcase
    // Three-byte forms combine the immediate with the direct byte
    alu_a = (dec.len == `LEN_THREE) ? byte3_ff : acc_ff;
  end

  alu8 u_alu (
    .op    (dec.op),
    .a     (alu_a),
    .b     (opnd),
    .bval  (b_ff),
    .cin   (cy_ff),
    .vin   (ov_ff),
    .res   (res),
    .res_b (res_b),
    .cout  (cout),
    .ovf   (ovf)
  );

  // ==========================================================
  // Architectural registers, committed on the last step only
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_ff  <= `ACC_RST;
      b_ff    <= `B_RST;
      cy_ff   <= 1'b0;
      ov_ff   <= 1'b0;
      data_pointer_16_ff <= `DATA_POINTER_16_RST;
    end
    else if (last && dec.op != OP_NONE)
    begin
      if (dec.dst == DST_ACC || dec.dst == DST_AB)
        acc_ff <= res;
      if (dec.dst == DST_AB)
        b_ff <= res_b;
      if (dec.dst == DST_DATA_POINTER_16)
        data_pointer_16_ff <= data_pointer_16_ff + 16'h0001;
      if (dec.op inside {OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_RLC, OP_RRC, OP_MUL, OP_DIV})
        cy_ff <= cout;
      if (dec.op inside {OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_MUL, OP_DIV})
        ov_ff <= ovf;
    end
  end

  // Posted write back to memory; next read is at least a fetch away
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ff    <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
    end
    else
    begin
      wr_ff <= last && dec.op != OP_NONE && dec.dst == DST_OPND;
      if (last && dec.dst == DST_OPND)
      begin
        waddr_ff <= (dec.src == SRC_IND) ? ptr_ff : opnd_addr;
        wdata_ff <= res;
      end
    end
  end

  assign dmem_wr         = wr_ff;
  assign dmem_waddr      = waddr_ff;
  assign dmem_wdata      = wdata_ff;
  assign acc_out         = acc_ff;
  assign b_out           = b_ff;
  assign carry_flag      = cy_ff;
  assign ovf_flag        = ov_ff;
  assign data_pointer_16 = data_pointer_16_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic exec_first;
  assign exec_first = (state_ff == ST_EXEC) && (step_ff == 3'h0);
  sequence s_long_start;
    exec_first && (dec.op == OP_MUL || dec.op == OP_DIV);
  endsequence
  sequence s_wait_eight;
    (!instr_done) [*7] ##1 instr_done;
  endsequence
  a_three_byte_fetch: assert property (
    take && state_ff == ST_FETCH && dec_in.len == `LEN_THREE |=> state_ff == ST_BYTE2
      ##0 (!take || nxt_state == ST_BYTE3))
    else $error("three-byte opcode did not fetch two more bytes");
  a_muldiv_eight: assert property (s_long_start |-> s_wait_eight)
    else $error("multiply or divide did not take eight cycles");
  a_add_two_cycle: assert property (
    exec_first && dec.op == OP_ADD |-> !instr_done ##1 instr_done)
    else $error("add did not complete in two cycles");
  a_reg_select: assert property (
    exec_first && dec.src == SRC_REG |-> dmem_rd && dmem_raddr[2:0] == opc_ff[2:0])
    else $error("register operand address wrong");
  a_ptr_select: assert property (
    exec_first && dec.src == SRC_IND |-> dmem_raddr[0] == opc_ff[0] && dmem_raddr[2:1] == 2'b00
      ##1 dmem_rd && dmem_raddr == $past(dmem_rdata))
    else $error("indirect pointer selection wrong");
  a_add_with_carry_sum: assert property (
    instr_done && dec.op == OP_ADD_WITH_CARRY |=>
      acc_ff == 8'($past(alu_a) + $past(opnd) + {7'h00, $past(cy_ff)}))
    else $error("add with carry result wrong");
  a_subtract_with_borrow_borrow: assert property (
    instr_done && dec.op == OP_SUBTRACT_WITH_BORROW |=>
      cy_ff == ({1'b0, $past(alu_a)} < {1'b0, $past(opnd)} + {8'h00, $past(cy_ff)}))
    else $error("subtract borrow flag wrong");
  a_data_pointer_16_step: assert property (
    exec_first && dec.op == OP_INCDP |-> ##3 instr_done
      ##1 data_pointer_16 == $past(data_pointer_16_ff) + 16'h0001)
    else $error("data pointer increment wrong");
  a_dir_write: assert property (
    instr_done && dec.dst == DST_OPND && dec.src == SRC_DIR && dec.op != OP_NONE |=>
      dmem_wr && dmem_waddr == $past(byte2_ff))
    else $error("direct byte write back missing");
  a_rotate_left: assert property (
    instr_done && dec.op == OP_RL |=> acc_ff == {$past(acc_ff[6:0]), $past(acc_ff[7])})
    else $error("rotate left result wrong");
endmodule

/* verif/prog_data_mem.sv */
// Purpose: program and data memory partner for the decoder
// Assumes: reads answer in the same cycle as the request
// Notes: idle lines show the inverse of the last value taken
`timescale 1ns/1ps
module prog_data_mem
(
  input  wire logic        sys_clk,
  input  wire logic        slow,
  input  wire logic        prog_rd,
  input  wire logic [15:0] prog_addr,
  output logic             prog_ready,
  output logic      [7:0]  prog_data,
  input  wire logic        dmem_rd,
  input  wire logic [7:0]  dmem_raddr,
  output logic      [7:0]  dmem_rdata,
  input  wire logic        dmem_wr,
  input  wire logic [7:0]  dmem_waddr,
  input  wire logic [7:0]  dmem_wdata
);
  logic [7:0] pmem [256];
  logic [7:0] dmem [256];
  logic       tog_ff = 1'b0;
  logic [7:0] plast_ff = 8'h00;
  logic [7:0] dlast_ff = 8'h00;

  // ==========================================================
  // Program side: slow mode answers only every other cycle
  always @(posedge sys_clk) tog_ff <= ~tog_ff;
  assign prog_ready = ~slow | tog_ff;
  // Stale value is never repeated, so a late sample shows up
  assign prog_data = (prog_rd && prog_ready) ? pmem[prog_addr[7:0]] : ~plast_ff;
  always @(posedge sys_clk)
  begin
    if (prog_rd && prog_ready) plast_ff <= pmem[prog_addr[7:0]];
  end

  // ==========================================================
  // Data side: combinational read, write on the pulse
  assign dmem_rdata = dmem_rd ? dmem[dmem_raddr] : ~dlast_ff;
  always @(posedge sys_clk)
  begin
    if (dmem_rd) dlast_ff <= dmem[dmem_raddr];
    if (dmem_wr) dmem[dmem_waddr] <= dmem_wdata;
  end
endmodule

/* verif/tb_top.sv */
// Purpose: self-checking bench for the arithmetic/logic decoder
// Assumes: memory partner answers reads combinationally
// Notes: expected values are worked out by hand in each scenario
`timescale 1ns/1ps
module tb_top;
  import decode_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst;
  logic [1:0]  bank_sel;
  logic        slow;
  logic        prog_ready, prog_rd, dmem_rd, dmem_wr, carry_flag, ovf_flag;
  logic        instr_done, unsupported_op;
  logic [7:0]  prog_data, dmem_rdata, dmem_raddr, dmem_waddr, dmem_wdata;
  logic [7:0]  acc_out, b_out;
  logic [15:0] prog_addr, data_pointer_16;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  logic        uns_s, wr_s;
  logic [7:0]  wa_s, wd_s;

  // ==========================================================
  // Clock, timeout and the two units
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    // Whole run needs well under a thousand cycles
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end
  arith_logic_instr_decode i_dut (.sys_clk(sys_clk), .nrst(nrst), .bank_sel(bank_sel),
    .prog_ready(prog_ready), .prog_data(prog_data), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .dmem_rdata(dmem_rdata), .dmem_rd(dmem_rd),
    .dmem_raddr(dmem_raddr), .dmem_wr(dmem_wr), .dmem_waddr(dmem_waddr),
    .dmem_wdata(dmem_wdata), .acc_out(acc_out), .b_out(b_out),
    .carry_flag(carry_flag), .ovf_flag(ovf_flag), .data_pointer_16(data_pointer_16),
    .instr_done(instr_done), .unsupported_op(unsupported_op));
  prog_data_mem i_mem (.sys_clk(sys_clk), .slow(slow), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_ready(prog_ready), .prog_data(prog_data),
    .dmem_rd(dmem_rd), .dmem_raddr(dmem_raddr), .dmem_rdata(dmem_rdata),
    .dmem_wr(dmem_wr), .dmem_waddr(dmem_waddr), .dmem_wdata(dmem_wdata));

  // ==========================================================
  // Compare and run helpers
  task automatic chk_val(input logic [15:0] act, input logic [15:0] exp);
    num_checks++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t value %h expected %h", $time, act, exp);
    end
  endtask

  task automatic chk_flag(input logic act, input logic exp);
    num_checks++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t flag %b expected %b", $time, act, exp);
    end
  endtask

  // Places one instruction at the fetch address and runs it to the end
  task automatic run_op(input logic [7:0] b0, b1, b2, input int len, input int cyc);
    logic [15:0] pc0;
    int          n;
    int          w;
    pc0 = prog_addr;
    n = 0;
    w = 0;
    i_mem.pmem[pc0[7:0]] = b0;
    i_mem.pmem[pc0[7:0] + 8'h01] = b1;
    i_mem.pmem[pc0[7:0] + 8'h02] = b2;
    while (instr_done !== 1'b1 && w < 60)
    begin
      @(negedge sys_clk);
      w++;
      if (prog_rd === 1'b0) n++;
    end
    uns_s = unsupported_op;
    chk_val(16'(n), 16'(cyc));
    @(negedge sys_clk);
    wr_s = dmem_wr;
    wa_s = dmem_waddr;
    wd_s = dmem_wdata;
    chk_val(prog_addr, pc0 + 16'(len));
  endtask

  // Runs a two-cycle accumulator form and checks the result and flags
  task automatic op_acc(input logic [7:0] b0, b1, input int len,
                        input logic [7:0] a, input logic c, input logic ov);
    run_op(b0, b1, 8'h00, len, 2);
    chk_flag(uns_s, 1'b0);
    chk_val(16'(acc_out), 16'(a));
    chk_flag(carry_flag, c);
    chk_flag(ovf_flag, ov);
  endtask

  // Runs a form that writes data memory and checks the posted write
  task automatic op_wr(input logic [7:0] b0, b1, b2, input int len, input int cyc,
                       input logic [7:0] wa, input logic [7:0] wd);
    run_op(b0, b1, b2, len, cyc);
    chk_flag(wr_s, 1'b1);
    chk_val(16'(wa_s), 16'(wa));
    chk_val(16'(wd_s), 16'(wd));
  endtask

  // The decoder fetches on every idle edge, so park a NOP there and let it finish
  task automatic set_in(input logic [1:0] bank, input logic slw);
    i_mem.pmem[prog_addr[7:0]] = 8'h00;
    @(posedge sys_clk);
    #2;
    bank_sel = bank;
    slow = slw;
    @(negedge sys_clk);
    while (instr_done !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_arith;
    op_acc(8'h24, 8'h7f, 2, 8'h7f, 1'b0, 1'b0);
    op_acc(8'h34, 8'h01, 2, 8'h80, 1'b0, 1'b1);
    op_acc(8'h34, 8'h80, 2, 8'h00, 1'b1, 1'b1);
    op_acc(8'h34, 8'h00, 2, 8'h01, 1'b0, 1'b0);
    op_acc(8'h94, 8'h02, 2, 8'hff, 1'b1, 1'b0);
    op_acc(8'h94, 8'h00, 2, 8'hfe, 1'b0, 1'b0);
    op_acc(8'h25, 8'h20, 2, 8'h01, 1'b1, 1'b0);
  endtask

  task automatic t_logic_rot;
    op_acc(8'h44, 8'hf0, 2, 8'hf1, 1'b1, 1'b0);
    op_acc(8'h54, 8'h3c, 2, 8'h30, 1'b1, 1'b0);
    op_acc(8'h64, 8'hff, 2, 8'hcf, 1'b1, 1'b0);
    op_acc(8'h23, 8'h00, 1, 8'h9f, 1'b1, 1'b0);
    op_acc(8'h33, 8'h00, 1, 8'h3f, 1'b1, 1'b0);
    op_acc(8'h03, 8'h00, 1, 8'h9f, 1'b1, 1'b0);
    op_acc(8'h13, 8'h00, 1, 8'hcf, 1'b1, 1'b0);
  endtask

  task automatic t_regs;
    set_in(2'b10, 1'b0);
    op_acc(8'h2d, 8'h00, 1, 8'he0, 1'b0, 1'b0);
    set_in(2'b01, 1'b0);
    op_acc(8'h5d, 8'h00, 1, 8'h20, 1'b0, 1'b0);
    set_in(2'b10, 1'b0);
    op_wr(8'h07, 8'h00, 8'h00, 1, 2, 8'h41, 8'h0a);
    op_wr(8'h16, 8'h00, 8'h00, 1, 2, 8'h40, 8'h04);
    op_acc(8'h66, 8'h00, 1, 8'h24, 1'b0, 1'b0);
    op_wr(8'h0d, 8'h00, 8'h00, 1, 2, 8'h15, 8'h12);
    op_wr(8'h1d, 8'h00, 8'h00, 1, 2, 8'h15, 8'h11);
  endtask

  // Program memory stalls every other cycle here
  task automatic t_direct;
    set_in(2'b10, 1'b1);
    op_wr(8'h05, 8'h30, 8'h00, 2, 2, 8'h30, 8'h00);
    chk_flag(carry_flag, 1'b0);
    op_wr(8'h15, 8'h30, 8'h00, 2, 2, 8'h30, 8'hff);
    op_wr(8'h53, 8'h31, 8'h0f, 3, 4, 8'h31, 8'h0b);
    op_wr(8'h43, 8'h31, 8'h70, 3, 4, 8'h31, 8'h7b);
    op_wr(8'h63, 8'h31, 8'hff, 3, 4, 8'h31, 8'h84);
    op_wr(8'h52, 8'h32, 8'h00, 2, 2, 8'h32, 8'h04);
    op_wr(8'h42, 8'h32, 8'h00, 2, 2, 8'h32, 8'h24);
    op_wr(8'h62, 8'h32, 8'h00, 2, 2, 8'h32, 8'h00);
  endtask

  task automatic t_long;
    set_in(2'b00, 1'b0);
    run_op(8'ha3, 8'h00, 8'h00, 1, 4);
    chk_val(data_pointer_16, 16'h0001);
    run_op(8'h84, 8'h00, 8'h00, 1, 8);
    chk_val({b_out, acc_out}, 16'h0024);
    chk_flag(ovf_flag, 1'b1);
    run_op(8'ha4, 8'h00, 8'h00, 1, 8);
    chk_val({b_out, acc_out}, 16'h0000);
    chk_flag(ovf_flag, 1'b0);
    op_acc(8'h04, 8'h00, 1, 8'h01, 1'b0, 1'b0);
    op_acc(8'h14, 8'h00, 1, 8'h00, 1'b0, 1'b0);
    run_op(8'h00, 8'h00, 8'h00, 1, 2);
    chk_flag(uns_s, 1'b1);
  endtask

  task automatic close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    bank_sel = 2'b00;
    slow = 1'b0;
    i_mem.dmem[8'h20] = 8'h03;
    i_mem.dmem[8'h15] = 8'h11;
    i_mem.dmem[8'h0d] = 8'h22;
    i_mem.dmem[8'h10] = 8'h40;
    i_mem.dmem[8'h11] = 8'h41;
    i_mem.dmem[8'h40] = 8'h05;
    i_mem.dmem[8'h41] = 8'h09;
    i_mem.dmem[8'h30] = 8'hff;
    i_mem.dmem[8'h31] = 8'hab;
    i_mem.dmem[8'h32] = 8'h0f;
    repeat (10) @(posedge sys_clk);
    #2;
    nrst = 1'b1;
    @(negedge sys_clk);
    chk_val({b_out, acc_out}, 16'h0000);
    chk_val(data_pointer_16, 16'h0000);
    chk_flag(carry_flag, 1'b0);
    chk_flag(dmem_wr, 1'b0);
    t_arith();
    t_logic_rot();
    t_regs();
    t_direct();
    t_long();
    close_out();
  end
endmodule
